// ### verilog/acd_params.svh
// Register map, field positions and reset values of the clock divider chain
`ifndef ACD_PARAMS_SVH
`define ACD_PARAMS_SVH
// ==========================================================
// Register indices
`define ACD_IDX_SRC_DIV 4'hD
`define ACD_IDX_MOD_OSR 4'hE
`define ACD_IDX_STATUS 4'hF
// ==========================================================
// Field positions
`define ACD_SRC_SEL_BIT 7
`define ACD_IN_DIV_MSB 3
`define ACD_IN_DIV_LSB 1
`define ACD_MOD_DIV_MSB 7
`define ACD_MOD_DIV_LSB 5
`define ACD_OSR_MSB 3
`define ACD_OSR_LSB 0
`define ACD_SRC_DIV_MASK 8'h8E
`define ACD_MOD_OSR_MASK 8'hEF
// ==========================================================
// Reset values
`define ACD_SRC_DIV_RST 8'h08
`define ACD_MOD_OSR_RST 8'h86
`endif

// ### verilog/acd_pkg.sv
// Types shared by the clock divider chain
package acd_pkg;
   typedef logic [7:0] acd_reg_t;
   typedef logic [2:0] acd_div_code_t;
   typedef logic [3:0] acd_osr_code_t;
   typedef logic [11:0] acd_count_t;
endpackage : acd_pkg

// ### verilog/acd_clock_chain.sv
// Clock source select, divider chain and register slave of the converter
`timescale 1ns/1ps
`default_nettype none
`include "acd_params.svh"

module acd_clock_chain
(
   // System
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [5:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Clock pins, sampled in clk_i domain
   input wire logic clock_input_pin_i,
   input wire logic serial_clock_pin_i,
   input wire logic sync_master_mode_i,
   // Divided clock outputs
   output logic serial_clock_o,
   output logic serial_clock_oe_o,
   output logic internal_divided_clock_o,
   output logic modulator_clock_o,
   output logic data_rate_strobe_o
);
   import acd_pkg::*;

   // ==========================================================
   // Helpers
   function automatic acd_count_t half_ratio(input acd_div_code_t code);
      // Even ratio 2*code; reserved code 000 treated as 001
      half_ratio = (code == 3'h0) ? 12'h001 : {9'h000, code};
   endfunction : half_ratio

   function automatic acd_count_t osr_ratio(input acd_osr_code_t code);
      unique case (code)
         4'h0: osr_ratio = 12'hFFF;
         4'h1: osr_ratio = 12'h7FF;
         4'h2: osr_ratio = 12'h3FF;
         4'h3: osr_ratio = 12'h31F;
         4'h4: osr_ratio = 12'h2FF;
         4'h5: osr_ratio = 12'h1FF;
         4'h6: osr_ratio = 12'h18F;
         4'h7: osr_ratio = 12'h17F;
         4'h8: osr_ratio = 12'h0FF;
         4'h9: osr_ratio = 12'h0C7;
         4'hA: osr_ratio = 12'h0BF;
         4'hB: osr_ratio = 12'h07F;
         4'hC: osr_ratio = 12'h05F;
         4'hD: osr_ratio = 12'h03F;
         4'hE: osr_ratio = 12'h02F;
         4'hF: osr_ratio = 12'h01F;
      endcase
   endfunction : osr_ratio

   // ==========================================================
   // Register slave
   acd_reg_t src_div_r;
   acd_reg_t mod_osr_r;
   logic wb_ack_r;
   logic [31:0] wb_dat_r;
   logic wb_hit;
   logic [3:0] wb_idx;

   assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_r;
   assign wb_idx = wb_adr_i[5:2];

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         src_div_r <= `ACD_SRC_DIV_RST;
         mod_osr_r <= `ACD_MOD_OSR_RST;
      end
      else if (wb_cyc_i && wb_stb_i && wb_ack_r && wb_we_i && wb_sel_i[0])
      begin
         // Reserved bits held at zero so readback shows what is used
         if (wb_idx == `ACD_IDX_SRC_DIV)
            src_div_r <= wb_dat_i[7:0] & `ACD_SRC_DIV_MASK;
         if (wb_idx == `ACD_IDX_MOD_OSR)
            mod_osr_r <= wb_dat_i[7:0] & `ACD_MOD_OSR_MASK;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wb_ack_r <= 1'b0;
         wb_dat_r <= 32'h0000_0000;
      end
      else
      begin
         wb_ack_r <= wb_hit;
         wb_dat_r <= 32'h0000_0000;
         if (wb_hit && !wb_we_i)
         begin
            unique case (wb_idx)
               `ACD_IDX_SRC_DIV: wb_dat_r <= {24'h000000, src_div_r};
               `ACD_IDX_MOD_OSR: wb_dat_r <= {24'h000000, mod_osr_r};
               `ACD_IDX_STATUS:
                  wb_dat_r <= {29'h0, data_rate_strobe_o,
                               modulator_clock_o, internal_divided_clock_o};
               default: wb_dat_r <= 32'h0000_0000;
            endcase
         end
      end
   end

   assign wb_ack_o = wb_ack_r;
   assign wb_dat_o = wb_dat_r;

   // ==========================================================
   // Pin synchronisers
   logic [1:0] pin_sync_r;
   logic [1:0] sclk_sync_r;
   logic [1:0] master_sync_r;
   logic src_level_r;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         pin_sync_r <= 2'b00;
         sclk_sync_r <= 2'b00;
         master_sync_r <= 2'b00;
      end
      else
      begin
         pin_sync_r <= {pin_sync_r[0], clock_input_pin_i};
         sclk_sync_r <= {sclk_sync_r[0], serial_clock_pin_i};
         master_sync_r <= {master_sync_r[0], sync_master_mode_i};
      end
   end

   // ==========================================================
   // Source select and rising-edge enable
   logic src_sel;
   logic src_now;
   logic src_tick;

   assign src_sel = src_div_r[`ACD_SRC_SEL_BIT];
   assign src_now = src_sel ? sclk_sync_r[1] : pin_sync_r[1];

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         src_level_r <= 1'b0;
      else
         src_level_r <= src_now;
   end

   assign src_tick = src_now && !src_level_r;

   // ==========================================================
   // Input divider to internal clock
   acd_count_t in_cnt_r;
   logic dclk_r;
   logic dclk_tick;
   acd_count_t in_half;

   assign in_half = half_ratio(src_div_r[`ACD_IN_DIV_MSB:`ACD_IN_DIV_LSB]);

   // Toggle every half ratio of source edges
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         in_cnt_r <= 12'h000;
         dclk_r <= 1'b0;
      end
      else if (src_tick)
      begin
         if (in_cnt_r + 12'h001 >= in_half)
         begin
            in_cnt_r <= 12'h000;
            dclk_r <= !dclk_r;
         end
         else
            in_cnt_r <= in_cnt_r + 12'h001;
      end
   end

   // One enable per internal clock period, on its rising toggle
   assign dclk_tick = src_tick && !dclk_r && (in_cnt_r + 12'h001 >= in_half);

   // ==========================================================
   // Modulator divider
   acd_count_t mod_cnt_r;
   logic mod_r;
   logic mod_tick;
   acd_count_t mod_half;

   assign mod_half = half_ratio(mod_osr_r[`ACD_MOD_DIV_MSB:`ACD_MOD_DIV_LSB]);

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         mod_cnt_r <= 12'h000;
         mod_r <= 1'b0;
      end
      else if (dclk_tick)
      begin
         if (mod_cnt_r + 12'h001 >= mod_half)
         begin
            mod_cnt_r <= 12'h000;
            mod_r <= !mod_r;
         end
         else
            mod_cnt_r <= mod_cnt_r + 12'h001;
      end
   end

   assign mod_tick = dclk_tick && !mod_r && (mod_cnt_r + 12'h001 >= mod_half);

   // ==========================================================
   // Oversampling counter, one strobe per output word
   acd_count_t osr_cnt_r;
   logic drdy_r;
   acd_count_t osr_last;

   assign osr_last = osr_ratio(mod_osr_r[`ACD_OSR_MSB:`ACD_OSR_LSB]);

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         osr_cnt_r <= 12'h000;
         drdy_r <= 1'b0;
      end
      else
      begin
         drdy_r <= 1'b0;
         if (mod_tick)
         begin
            // Ratio shrink below count wraps at once, not after 4096
            if (osr_cnt_r >= osr_last)
            begin
               osr_cnt_r <= 12'h000;
               drdy_r <= 1'b1;
            end
            else
               osr_cnt_r <= osr_cnt_r + 12'h001;
         end
      end
   end

   // ==========================================================
   // Outputs
   logic sclk_out_r;
   logic sclk_oe_r;

   // Serial clock driven only in master mode
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         sclk_out_r <= 1'b0;
         sclk_oe_r <= 1'b0;
      end
      else
      begin
         sclk_oe_r <= master_sync_r[1] && !src_sel;
         sclk_out_r <= master_sync_r[1] && !src_sel && dclk_r;
      end
   end

   assign serial_clock_o = sclk_out_r;
   assign serial_clock_oe_o = sclk_oe_r;
   assign internal_divided_clock_o = dclk_r;
   assign modulator_clock_o = mod_r;
   assign data_rate_strobe_o = drdy_r;

   // ==========================================================
   // Checks
   // Reset values, master-mode drive, strobe width and wrap
   chk_src_div_reset: assert property (@(posedge clk_i)
      $past(rst_i) |-> src_div_r == `ACD_SRC_DIV_RST)
      else $error("source divider register reset value wrong");

   chk_mod_osr_reset: assert property (@(posedge clk_i)
      $past(rst_i) |-> mod_osr_r == `ACD_MOD_OSR_RST)
      else $error("modulator register reset value wrong");

   chk_sclk_drive_mode: assert property (@(posedge clk_i)
      disable iff (rst_i) serial_clock_oe_o |-> $past(master_sync_r[1]))
      else $error("serial clock driven outside master mode");

   chk_drdy_single_pulse: assert property (@(posedge clk_i)
      disable iff (rst_i) data_rate_strobe_o |=> !data_rate_strobe_o)
      else $error("data strobe longer than one cycle");

   chk_osr_wrap_strobe: assert property (@(posedge clk_i)
      disable iff (rst_i) data_rate_strobe_o |-> osr_cnt_r == 12'h000)
      else $error("data strobe without counter wrap");

   // Modulator toggles only on internal enable
   chk_mod_on_int_clk: assert property (@(posedge clk_i)
      disable iff (rst_i) $changed(mod_r) |-> $past(dclk_tick))
      else $error("modulator clock moved without internal enable");

   // Internal clock toggles only on source edge
   chk_int_clk_on_src: assert property (@(posedge clk_i)
      disable iff (rst_i) $changed(dclk_r) |-> $past(src_tick))
      else $error("internal clock moved without source edge");

   // Only the selected pin can move the internal clock
   chk_src_select: assert property (@(posedge clk_i)
      disable iff (rst_i) $changed(dclk_r) |->
      $past(src_sel ? sclk_sync_r[1] : pin_sync_r[1]))
      else $error("source mux ignores select bit");
   // Bus ack is one cycle
   chk_ack_single: assert property (@(posedge clk_i)
      disable iff (rst_i) wb_ack_o |=> !wb_ack_o)
      else $error("bus ack held more than one cycle");
endmodule : acd_clock_chain
`default_nettype wire

// ### tb/acd_pin_clock_model.sv
// Clock sources standing at the converter clock pins
`timescale 1ns/1ps
`default_nettype none
module acd_pin_clock_model
#(
   parameter int HALF_PIN = 2,
   parameter int HALF_SER = 3
)
(
   // System
   input wire logic clk_i,
   // Clock pins
   output logic clock_input_pin_o,
   output logic serial_clock_pin_o
);
   int cnt_pin_r = 0;
   int cnt_ser_r = 0;
   // ==========================================================
   // Sources
   // Both run free: the chain uses either one as its clock source
   initial clock_input_pin_o = 1'b0;
   initial serial_clock_pin_o = 1'b0;
   always @(posedge clk_i)
   begin
      cnt_pin_r <= (cnt_pin_r == HALF_PIN - 1) ? 0 : cnt_pin_r + 1;
      cnt_ser_r <= (cnt_ser_r == HALF_SER - 1) ? 0 : cnt_ser_r + 1;
      if (cnt_pin_r == HALF_PIN - 1)
         clock_input_pin_o <= ~clock_input_pin_o;
      if (cnt_ser_r == HALF_SER - 1)
         serial_clock_pin_o <= ~serial_clock_pin_o;
   end
endmodule : acd_pin_clock_model
`default_nettype wire

// ### tb/acd_clock_chain_tb_top.sv
// Self-checking bench for the clock divider chain
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin \
   n_mismatch++; \
   $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module acd_clock_chain_tb_top;
   typedef struct {logic [5:0] a; logic [3:0] s; logic [31:0] d;
      logic [31:0] e;} acd_row_s;
   localparam int P = 4;
   localparam int Q = 6;
   logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [5:0] wb_adr_i;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, q;
   logic pin_w, ser_w, mode_r, sclk_w, soe_w, dclk_w, mclk_w, strb_w;
   int n_mismatch = 0;
   int compares = 0;
   int n;
   int osr_t[16] = '{4096, 2048, 1024, 800, 768, 512, 400, 384, 256,
      200, 192, 128, 96, 64, 48, 32};
   acd_row_s rows[6] = '{'{6'h34, 4'hF, 32'hFF, 32'h8E},
      '{6'h38, 4'hF, 32'hFF, 32'hEF}, '{6'h34, 4'hE, 32'h00, 32'h8E},
      '{6'h00, 4'hF, 32'hFF, 32'h00}, '{6'h34, 4'hF, 32'h02, 32'h02},
      '{6'h38, 4'hF, 32'h21, 32'h21}};
   // ==========================================================
   // Clock, partner and design
   initial
   begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end
   acd_pin_clock_model #(.HALF_PIN(P / 2), .HALF_SER(Q / 2)) pins (
      .clk_i(clk_i), .clock_input_pin_o(pin_w),
      .serial_clock_pin_o(ser_w));
   acd_clock_chain uut (.clk_i(clk_i), .rst_i(rst_i),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .clock_input_pin_i(pin_w), .serial_clock_pin_i(ser_w),
      .sync_master_mode_i(mode_r), .serial_clock_o(sclk_w),
      .serial_clock_oe_o(soe_w), .internal_divided_clock_o(dclk_w),
      .modulator_clock_o(mclk_w), .data_rate_strobe_o(strb_w));
   // ==========================================================
   // Helpers
   function automatic logic sv(input int s);
      case (s)
         0: return dclk_w;
         1: return mclk_w;
         2: return strb_w;
         default: return sclk_w;
      endcase
   endfunction : sv
   function automatic int rt(input int c);
      return (c == 0) ? 2 : 2 * c;
   endfunction : rt
   // One classic cycle; held until ack is sampled high
   task automatic wb(input logic [5:0] a, input logic [3:0] s,
      input logic w, input logic [31:0] d);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_sel_i <= s;
      wb_dat_i <= d;
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_i);
   endtask : wb
   // First edge after a change is skipped, the next full period counted
   task automatic per(input int s);
      while (sv(s) !== 1'b0) @(posedge clk_i);
      while (sv(s) !== 1'b1) @(posedge clk_i);
      n = 0;
      while (sv(s) !== 1'b0) begin @(posedge clk_i); n++; end
      while (sv(s) !== 1'b1) begin @(posedge clk_i); n++; end
   endtask : per
   task automatic results;
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : results
   initial
   begin
      // All checked ratios together need about 80k cycles in all
      repeat (90000) @(posedge clk_i);
      n_mismatch++;
      results();
   end
   // ==========================================================
   // Tests
   initial
   begin
      rst_i = 1'b1;
      {wb_cyc_i, wb_stb_i, wb_we_i, mode_r} = 4'h0;
      wb_adr_i = 6'h00;
      wb_sel_i = 4'h0;
      wb_dat_i = 32'h0;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      foreach (rows[i])
      begin
         wb(rows[i].a, rows[i].s, 1'b1, rows[i].d);
         wb(rows[i].a, 4'hF, 1'b0, 32'h0);
         `CHK("reg row", rows[i].e, q)
      end
      rst_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      wb(6'h34, 4'hF, 1'b0, 32'h0);
      `CHK("reset src", 32'h08, q)
      wb(6'h38, 4'hF, 1'b0, 32'h0);
      `CHK("reset mod", 32'h86, q)
      `CHK("oe idle", 1'b0, soe_w)
      per(1);
      `CHK("default mod", 64 * P, n)
      for (int c = 0; c < 8; c++)
      begin
         wb(6'h34, 4'hF, 1'b1, 32'(2 * c));
         per(0);
         `CHK("in div", rt(c) * P, n)
      end
      wb(6'h34, 4'hF, 1'b1, 32'h02);
      for (int c = 0; c < 8; c++)
      begin
         wb(6'h38, 4'hF, 1'b1, 32'(32 * c + 15));
         per(1);
         `CHK("mod div", rt(c) * 2 * P, n)
      end
      // Slowest ratios are set only, to keep the run short
      for (int c = 0; c < 16; c++)
      begin
         wb(6'h38, 4'hF, 1'b1, 32'(32 + c));
         if (osr_t[c] <= 512) per(2);
         if (osr_t[c] <= 512) `CHK("osr", osr_t[c] * 4 * P, n)
      end
      mode_r <= 1'b1;
      repeat (8) @(posedge clk_i);
      `CHK("oe on", 1'b1, soe_w)
      per(3);
      `CHK("sclk out", 2 * P, n)
      wb(6'h34, 4'hF, 1'b1, 32'h82);
      repeat (8) @(posedge clk_i);
      `CHK("oe off", 1'b0, soe_w)
      `CHK("sclk low", 1'b0, sclk_w)
      per(0);
      `CHK("ser src", 2 * Q, n)
      results();
   end
endmodule : acd_clock_chain_tb_top
`default_nettype wire
